// ---- rtl/drcd_divider.sv ----
`default_nettype none

`include "drcd_cfg.svh"

// Contract
// - gate changes only while clock low
// - gate captured on falling input edge
// - no output phase assumed before reset
// - both paths stay in step without reset
// - both paths run from one clock
// - gate low, reset low: divide
// - gate high, reset low: hold all outputs
// - reset high: outputs held reset
// - pair A divides by 2 or 4
// - pair B divides by 4 or 6
// - undriven inputs read as low
module drcd_divider (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic in_clk_i,
  input wire logic gate_i,
  input wire logic master_reset_i,
  input wire logic ratio_select_a_i,
  input wire logic ratio_select_b_i,
  input wire drcd_pkg::drcd_apb_req_t apb_req_i,
  output logic [`DRCD_DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [3:0] divided_outputs_o
);
  import drcd_pkg::*;

  // ==========================================================
  // pin synchronisers
  drcd_pins_t pins_raw;
  drcd_pins_t pins_s;

  // group the raw pins for the two-stage capture
  assign pins_raw.in_clk = in_clk_i;
  assign pins_raw.gate = gate_i;
  assign pins_raw.master_reset = master_reset_i;
  assign pins_raw.ratio_select_a = ratio_select_a_i;
  assign pins_raw.ratio_select_b = ratio_select_b_i;

  drcd_sync i_drcd_sync (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .pins_i(pins_raw),
    .pins_o(pins_s)
  );

  // ==========================================================
  // divider arithmetic

  // one common phase counter, period twelve
  function automatic logic [3:0] phase_next(input logic [3:0] p);
    logic [3:0] n;
    n = 4'h0;
    if (p != `DRCD_PHASE_LAST)
    begin
      n = p + 4'h1;
    end
    return n;
  endfunction

  // high for the first half of each ratio period
  function automatic logic div_high(
    input logic [3:0] p,
    input logic [3:0] ratio
  );
    logic [3:0] m;
    m = p % ratio;
    return m < (ratio >> 1);
  endfunction

  // all four outputs from one phase value
  function automatic logic [3:0] outs_of(
    input logic [3:0] p,
    input logic sel_a,
    input logic sel_b
  );
    logic [3:0] ra;
    logic [3:0] rb;
    logic qa;
    logic qb;
    ra = sel_a ? `DRCD_RATIO_A_HI : `DRCD_RATIO_A_LO;
    rb = sel_b ? `DRCD_RATIO_B_HI : `DRCD_RATIO_B_LO;
    qa = div_high(p, ra);
    qb = div_high(p, rb);
    return {qb, qb, qa, qa};
  endfunction

  // ==========================================================
  // state
  drcd_state_t r;
  drcd_state_t r_nxt;

  // ==========================================================
  // next-state logic
  always_comb
  begin
    logic rise;
    logic fall;
    logic mr_eff;
    logic gate_in;
    logic sel_a;
    logic sel_b;
    logic advance;
    logic acc;
    logic wr_done;
    logic [1:0] evt_set;
    logic [1:0] evt_clr;
    logic [3:0] p_nxt;
    rise = 1'b0;
    fall = 1'b0;
    mr_eff = 1'b0;
    gate_in = 1'b0;
    sel_a = 1'b0;
    sel_b = 1'b0;
    advance = 1'b0;
    acc = 1'b0;
    wr_done = 1'b0;
    evt_set = 2'h0;
    evt_clr = 2'h0;
    p_nxt = 4'h0;
    r_nxt = r;

    // edges of the sampled input clock
    rise = pins_s.in_clk & ~r.clk_prev;
    fall = ~pins_s.in_clk & r.clk_prev;
    r_nxt.clk_prev = pins_s.in_clk;

    // pin and software sources merged
    mr_eff = pins_s.master_reset | r.ctrl.sw_reset;
    gate_in = pins_s.gate | r.ctrl.sw_hold;
    sel_a = r.ctrl.sel_ovr ? r.ctrl.sw_sel_a : pins_s.ratio_select_a;
    sel_b = r.ctrl.sel_ovr ? r.ctrl.sw_sel_b : pins_s.ratio_select_b;

    // gate sampled on the falling edge, so it acts while low
    if (fall)
    begin
      r_nxt.gate_q = gate_in;
    end

    // advance only on a rising edge with gate low
    advance = rise & ~r.gate_q & ~mr_eff;
    p_nxt = phase_next(r.phase);

    // divider core: reset, divide, or hold
    if (mr_eff)
    begin
      r_nxt.phase = `DRCD_PHASE_LAST;
      r_nxt.outs = 4'h0;
    end
    else if (advance)
    begin
      r_nxt.phase = p_nxt;
      r_nxt.outs = outs_of(p_nxt, sel_a, sel_b);
    end
    else
    begin
      r_nxt.outs = r.outs;
    end

    // sticky events seen by software
    evt_set[`DRCD_EVT_HOLD_BIT] = fall & gate_in & ~r.gate_q;
    evt_set[`DRCD_EVT_RESET_BIT] = mr_eff;

    // bus access phase
    acc = apb_req_i.psel & apb_req_i.penable;
    wr_done = (r.st == DRCD_RESP) & acc & apb_req_i.pwrite & ~r.pslverr;

    // bus slave: one wait cycle, then answer
    case (r.st)
      DRCD_IDLE:
      begin
        r_nxt.pready = 1'b0;
        r_nxt.pslverr = 1'b0;
        if (acc)
        begin
          r_nxt.st = DRCD_RESP;
          r_nxt.pready = 1'b1;
          r_nxt.prdata = '0;
          if (apb_req_i.paddr == `DRCD_OFF_CTRL)
          begin
            r_nxt.prdata[4:0] = r.ctrl;
          end
          else if (apb_req_i.paddr == `DRCD_OFF_STATUS)
          begin
            r_nxt.prdata[`DRCD_STAT_OUTS_LSB +: 4] = r.outs;
            r_nxt.prdata[`DRCD_STAT_HOLD_BIT] = r.gate_q;
            r_nxt.prdata[`DRCD_STAT_RESET_BIT] = mr_eff;
            r_nxt.prdata[`DRCD_STAT_SEL_A_BIT] = sel_a;
            r_nxt.prdata[`DRCD_STAT_SEL_B_BIT] = sel_b;
            r_nxt.prdata[`DRCD_STAT_PHASE_LSB +: 4] = r.phase;
          end
          else if (apb_req_i.paddr == `DRCD_OFF_EVENTS)
          begin
            r_nxt.prdata[1:0] = r.events;
          end
          else if (apb_req_i.paddr == `DRCD_OFF_EDGES)
          begin
            r_nxt.prdata[15:0] = r.edges;
          end
          else
          begin
            r_nxt.pslverr = 1'b1;
          end
        end
      end
      DRCD_RESP:
      begin
        r_nxt.st = DRCD_IDLE;
        r_nxt.pready = 1'b0;
        r_nxt.pslverr = 1'b0;
        r_nxt.prdata = '0;
      end
      default:
      begin
        r_nxt.st = DRCD_IDLE;
        r_nxt.pready = 1'b0;
        r_nxt.pslverr = 1'b0;
      end
    endcase

    // writes take effect at the completing edge
    if (wr_done && apb_req_i.paddr == `DRCD_OFF_CTRL)
    begin
      r_nxt.ctrl.sw_hold = apb_req_i.pwdata[`DRCD_CTRL_HOLD_BIT];
      r_nxt.ctrl.sw_reset = apb_req_i.pwdata[`DRCD_CTRL_RESET_BIT];
      r_nxt.ctrl.sel_ovr = apb_req_i.pwdata[`DRCD_CTRL_OVR_BIT];
      r_nxt.ctrl.sw_sel_a = apb_req_i.pwdata[`DRCD_CTRL_SEL_A_BIT];
      r_nxt.ctrl.sw_sel_b = apb_req_i.pwdata[`DRCD_CTRL_SEL_B_BIT];
    end

    // write-one-to-clear events
    if (wr_done && apb_req_i.paddr == `DRCD_OFF_EVENTS)
    begin
      evt_clr = apb_req_i.pwdata[1:0];
    end

    // a new event wins over a clear in the same cycle
    r_nxt.events = (r.events & ~evt_clr) | evt_set;

    // advance counter: any write clears, a count wins
    if (wr_done && apb_req_i.paddr == `DRCD_OFF_EDGES)
    begin
      r_nxt.edges = advance ? 16'h0001 : 16'h0000;
    end
    else if (advance)
    begin
      r_nxt.edges = r.edges + 16'h0001;
    end
  end

  // ==========================================================
  // state register; phase starts one before the common start
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      r.st <= DRCD_IDLE;
      r.pready <= 1'b0;
      r.pslverr <= 1'b0;
      r.prdata <= '0;
      r.ctrl <= `DRCD_CTRL_RST;
      r.events <= `DRCD_EVT_RST;
      r.edges <= `DRCD_EDGES_RST;
      r.phase <= `DRCD_PHASE_LAST;
      r.gate_q <= 1'b0;
      r.clk_prev <= 1'b0;
      r.outs <= 4'h0;
    end
    else
    begin
      r <= r_nxt;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign prdata_o = r.prdata;
  assign pready_o = r.pready;
  assign pslverr_o = r.pslverr;
  assign divided_outputs_o = r.outs;

endmodule

`default_nettype wire

// ---- pkg/drcd_cfg.svh ----
`ifndef DRCD_CFG_SVH
`define DRCD_CFG_SVH

// ==========================================================
// bus geometry
`define DRCD_ADDR_W 8
`define DRCD_DATA_W 32

// ==========================================================
// register offsets
`define DRCD_OFF_CTRL 8'h00
`define DRCD_OFF_STATUS 8'h04
`define DRCD_OFF_EVENTS 8'h08
`define DRCD_OFF_EDGES 8'h0C

// ==========================================================
// control field positions
`define DRCD_CTRL_HOLD_BIT 0
`define DRCD_CTRL_RESET_BIT 1
`define DRCD_CTRL_OVR_BIT 2
`define DRCD_CTRL_SEL_A_BIT 3
`define DRCD_CTRL_SEL_B_BIT 4

// ==========================================================
// status field positions
`define DRCD_STAT_OUTS_LSB 0
`define DRCD_STAT_HOLD_BIT 4
`define DRCD_STAT_RESET_BIT 5
`define DRCD_STAT_SEL_A_BIT 6
`define DRCD_STAT_SEL_B_BIT 7
`define DRCD_STAT_PHASE_LSB 8

// ==========================================================
// event field positions
`define DRCD_EVT_HOLD_BIT 0
`define DRCD_EVT_RESET_BIT 1

// ==========================================================
// reset values and divider constants
`define DRCD_CTRL_RST 5'h00
`define DRCD_EVT_RST 2'h0
`define DRCD_EDGES_RST 16'h0000
`define DRCD_PHASE_LAST 4'hB
`define DRCD_RATIO_A_LO 4'h2
`define DRCD_RATIO_A_HI 4'h4
`define DRCD_RATIO_B_LO 4'h4
`define DRCD_RATIO_B_HI 4'h6

`endif

// ---- pkg/drcd_pkg.sv ----
`default_nettype none

`include "drcd_cfg.svh"

package drcd_pkg;

  // ==========================================================
  // bus carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`DRCD_ADDR_W-1:0] paddr;
    logic [`DRCD_DATA_W-1:0] pwdata;
  } drcd_apb_req_t;

  // ==========================================================
  // pins as sampled: clock, gate, reset, selects
  typedef struct packed {
    logic in_clk;
    logic gate;
    logic master_reset;
    logic ratio_select_a;
    logic ratio_select_b;
  } drcd_pins_t;

  typedef struct packed {
    drcd_pins_t s1;
    drcd_pins_t s2;
  } drcd_sync_t;

  // ==========================================================
  // bus slave states, one-hot
  typedef enum logic [1:0] {
    DRCD_IDLE = 2'b01,
    DRCD_RESP = 2'b10
  } drcd_bus_st_t;

  typedef struct packed {
    logic sw_sel_b;
    logic sw_sel_a;
    logic sel_ovr;
    logic sw_reset;
    logic sw_hold;
  } drcd_ctrl_t;

  // ==========================================================
  // whole state of the divider core
  typedef struct packed {
    drcd_bus_st_t st;
    logic pready;
    logic pslverr;
    logic [`DRCD_DATA_W-1:0] prdata;
    drcd_ctrl_t ctrl;
    logic [1:0] events;
    logic [15:0] edges;
    logic [3:0] phase;
    logic gate_q;
    logic clk_prev;
    logic [3:0] outs;
  } drcd_state_t;

endpackage

`default_nettype wire

// ---- rtl/drcd_sync.sv ----
`default_nettype none

`include "drcd_cfg.svh"

module drcd_sync (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire drcd_pkg::drcd_pins_t pins_i,
  output drcd_pkg::drcd_pins_t pins_o
);
  import drcd_pkg::*;

  drcd_sync_t r;
  drcd_sync_t r_nxt;

  // ==========================================================
  // two-stage capture of the pin levels
  always_comb
  begin
    r_nxt = r;
    r_nxt.s1 = pins_i;
    r_nxt.s2 = r.s1;
  end

  // undriven pins read as low from reset
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= r_nxt;
    end
  end

  assign pins_o = r.s2;

endmodule

`default_nettype wire

// ---- tb/drcd_divider_chk.sv ----
`default_nettype none
module drcd_divider_chk (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic in_clk_i,
  input wire logic gate_i,
  input wire logic master_reset_i,
  input wire logic ratio_select_a_i,
  input wire logic ratio_select_b_i,
  input wire logic [3:0] divided_outputs_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] q;
  logic mr_seen_r;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // ====
  // alias and reset tracker
  assign q = divided_outputs_o;
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
    if (sys_rst_i)
      mr_seen_r <= 1'b1;
    else if (master_reset_i)
      mr_seen_r <= 1'b1;
    else if ($changed(q) && q != 4'h0)
      mr_seen_r <= 1'b0;
  // ====
  // output relations
  property p_pair;
    q[1] == q[0] && q[3] == q[2];
  endproperty
  a_pair: assert property (p_pair) else $error("pair split");
  property p_reset;
    master_reset_i [*4] |-> q == 4'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("not reset");
  property p_adv;
    $changed(q) && q != 4'h0 |-> $past(in_clk_i, 3) && !$past(in_clk_i, 4);
  endproperty
  a_adv: assert property (p_adv) else $error("stray edge");
  property p_start;
    mr_seen_r && $changed(q) && q != 4'h0 |-> q == 4'hF;
  endproperty
  a_start: assert property (p_start) else $error("bad start");
  property p_hold;
    gate_i && $fell(in_clk_i) |=> $stable(q) [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("no hold");
  property p_fall;
    !gate_i && !ratio_select_a_i && $fell(in_clk_i) ##[1:6] $rose(in_clk_i)
      |-> ##3 $changed(q[0]);
  endproperty
  a_fall: assert property (p_fall) else $error("no advance");
  property p_quad;
    $rose(q[0]) && ratio_select_a_i |-> ##11 q[0];
  endproperty
  a_quad: assert property (p_quad) else $error("short A");
  property p_six;
    $rose(q[2]) && ratio_select_b_i |-> ##17 q[2];
  endproperty
  a_six: assert property (p_six) else $error("short B");
endmodule
bind drcd_divider drcd_divider_chk i_drcd_divider_chk (.core_clk_i,
  .sys_rst_i, .in_clk_i, .gate_i, .master_reset_i, .ratio_select_a_i,
  .ratio_select_b_i, .divided_outputs_o);
`default_nettype wire

// ---- tb/drcd_src.sv ----
`default_nettype none
module drcd_src (
  input wire logic core_clk_i,
  output logic in_clk_o,
  output logic gate_o,
  output logic master_reset_o,
  output logic ratio_select_a_o,
  output logic ratio_select_b_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ====
  // control idles low, input clock stands still
  initial
  begin
    in_clk_o = 1'b0;
    gate_o = 1'b0;
    master_reset_o = 1'b0;
    ratio_select_a_o = 1'b0;
    ratio_select_b_o = 1'b0;
  end
  // master reset and ratios, then let the sync settle
  task automatic ctl(input logic mr, input logic sa, input logic sb);
    @(posedge core_clk_i);
    master_reset_o <= mr;
    ratio_select_a_o <= sa;
    ratio_select_b_o <= sb;
    repeat (4) @(posedge core_clk_i);
  endtask
  // one input period: gate gh from the rise, gl late in the low half
  task automatic cyc(input logic gh, input logic gl);
    @(posedge core_clk_i);
    in_clk_o <= 1'b1;
    gate_o <= gh;
    repeat (4) @(posedge core_clk_i);
    in_clk_o <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    gate_o <= gl;
    repeat (2) @(posedge core_clk_i);
  endtask
endmodule
`default_nettype wire

// ---- tb/drcd_divider_tb.sv ----
`default_nettype none
`include "drcd_cfg.svh"
module drcd_divider_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import drcd_pkg::*;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic in_clk, gate, mr, sel_a, sel_b, pready_o, pslverr_o, err;
  drcd_apb_req_t apb_req_i = '0;
  logic [31:0] prdata_o, rd;
  logic [3:0] q;
  int n_mismatch = 0;
  int n_tests = 0;
  int s, p;
  int ph[5] = '{0, 1, 1, 1, 2};
  logic [4:0] gh = 5'h06;
  logic [4:0] gl = 5'h03;
  always #12.5 core_clk_i = ~core_clk_i;
  drcd_divider i_drcd_divider (.core_clk_i, .sys_rst_i, .in_clk_i(in_clk),
    .gate_i(gate), .master_reset_i(mr), .ratio_select_a_i(sel_a),
    .ratio_select_b_i(sel_b), .apb_req_i, .prdata_o, .pready_o, .pslverr_o,
    .divided_outputs_o(q));
  drcd_src i_drcd_src (.core_clk_i, .in_clk_o(in_clk), .gate_o(gate),
    .master_reset_o(mr), .ratio_select_a_o(sel_a), .ratio_select_b_o(sel_b));
  // ====
  // compare, verdict, bus cycle, expected outputs
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int i = 0;
    @(posedge core_clk_i);
    apb_req_i <= {1'b1, 1'b0, w, a, d};
    @(posedge core_clk_i);
    apb_req_i.penable <= 1'b1;
    do
    begin
      @(posedge core_clk_i);
      i++;
    end
    while (pready_o !== 1'b1 && i < 8);
    rd = prdata_o;
    err = pslverr_o;
    apb_req_i <= '0;
    if (pready_o !== 1'b1)
    begin
      n_mismatch++;
      finish_test();
    end
  endtask
  function automatic logic [3:0] expq(int p, logic sa, logic sb);
    logic a, b;
    a = sa ? p % 4 < 2 : p % 2 == 0;
    b = sb ? p % 6 < 3 : p % 4 < 2;
    return {b, b, a, a};
  endfunction
  // ====
  // main sequence
  initial
  begin
    repeat (20) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    // register reset values, unmapped word, read-write
    for (s = 0; s < 16; s += 4)
    begin
      apb(1'b0, s[7:0], 32'h0);
      chk("reg", rd, s == 4 ? 32'h00000B00 : 32'h0);
    end
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    apb(1'b1, `DRCD_OFF_CTRL, 32'h18);
    apb(1'b0, `DRCD_OFF_CTRL, 32'h0);
    chk("ctrl", rd, 32'h18);
    apb(1'b1, `DRCD_OFF_CTRL, 32'h0);
    // every ratio pair, each from a master reset
    for (s = 3; s >= 0; s--)
    begin
      i_drcd_src.ctl(1'b1, s[0], s[1]);
      i_drcd_src.cyc(1'b0, 1'b0);
      chk("reset", q, 4'h0);
      i_drcd_src.ctl(1'b0, s[0], s[1]);
      apb(1'b1, `DRCD_OFF_EDGES, 32'h0);
      for (p = 0; p < 12; p++)
      begin
        i_drcd_src.cyc(1'b0, 1'b0);
        chk("outs", q, expq(p, s[0], s[1]));
      end
      apb(1'b0, `DRCD_OFF_EDGES, 32'h0);
      chk("edges", rd, 32'hC);
    end
    // gate raised in low half, held, then released
    for (p = 0; p < 5; p++)
    begin
      i_drcd_src.cyc(gh[p], gl[p]);
      chk("gate", q, expq(ph[p], 1'b0, 1'b0));
    end
    // hold and reset events seen, then cleared by writing ones
    apb(1'b0, `DRCD_OFF_EVENTS, 32'h0);
    chk("events", rd, 32'h3);
    apb(1'b1, `DRCD_OFF_EVENTS, 32'h3);
    apb(1'b0, `DRCD_OFF_EVENTS, 32'h0);
    chk("events clr", rd, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
